// file: verilog/srfu_consts.svh
`ifndef SRFU_CONSTS_SVH
`define SRFU_CONSTS_SVH

// Status flag positions
`define SRFU_FLAG_C 0
`define SRFU_FLAG_Z 1
`define SRFU_FLAG_N 2
`define SRFU_FLAG_V 3
`define SRFU_FLAG_S 4
`define SRFU_FLAG_H 5
`define SRFU_FLAG_T 6
`define SRFU_FLAG_I 7

`define SRFU_FLAGS_RST 8'h00

// APB byte offsets
`define SRFU_OFF_FLAGS 8'h00
`define SRFU_OFF_RESULT 8'h04
`define SRFU_OFF_CTRL 8'h08
`define SRFU_OFF_STATE 8'h0C

// Control register fields
`define SRFU_CTRL_EXEC_EN 0
`define SRFU_CTRL_BRK_EN 1
`define SRFU_CTRL_RST 2'h3

// State register fields
`define SRFU_STATE_HALT 0
`define SRFU_STATE_RDY 1

// Every documented operation finishes in this many clocks
`define SRFU_OP_CYCLES 1

`endif

// file: verilog/srfu_pkg.sv
package srfu_pkg;

  typedef enum logic [4:0] {
    OP_IDLE_INSTRUCTION = 5'h00,
    OP_SHIFT_LEFT_LOGICAL = 5'h01,
    OP_SHIFT_RIGHT_LOGICAL = 5'h02,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h03,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h04,
    OP_SHIFT_RIGHT_ARITH = 5'h05,
    OP_NIBBLE_EXCHANGE = 5'h06,
    OP_FLAG_SET_BY_INDEX = 5'h07,
    OP_FLAG_CLEAR_BY_INDEX = 5'h08,
    OP_BIT_TO_TRANSFER_FLAG = 5'h09,
    OP_TRANSFER_FLAG_TO_BIT = 5'h0A,
    OP_CARRY_SET = 5'h0B,
    OP_CARRY_CLEAR = 5'h0C,
    OP_NEGATIVE_SET = 5'h0D,
    OP_NEGATIVE_CLEAR = 5'h0E,
    OP_ZERO_SET = 5'h0F,
    OP_ZERO_CLEAR = 5'h10,
    OP_IRQ_ENABLE = 5'h11,
    OP_IRQ_DISABLE = 5'h12,
    OP_SIGNED_FLAG_SET_OP = 5'h13,
    OP_SIGNED_FLAG_CLEAR_OP = 5'h14,
    OP_OVERFLOW_FLAG_SET_OP = 5'h15,
    OP_OVERFLOW_FLAG_CLEAR_OP = 5'h16,
    OP_TRANSFER_FLAG_SET_OP = 5'h17,
    OP_TRANSFER_FLAG_CLEAR_OP = 5'h18,
    OP_HALF_CARRY_CLEAR_OP = 5'h19,
    OP_SLEEP = 5'h1A,
    OP_WATCHDOG_RESTART_OP = 5'h1B,
    OP_DEBUG_BREAK = 5'h1C
  } srfu_op_e;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_HALT = 1'b1
  } srfu_state_e;

endpackage

// file: verilog/srfu_apb_regs.sv
`timescale 1ns/1ps
`include "srfu_consts.svh"

module srfu_apb_regs import srfu_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] flags,
  input wire logic [DATA_W-1:0] result,
  input wire logic halted,
  input wire logic op_ready,
  output logic exec_en,
  output logic brk_en,
  output logic flags_we,
  output logic [7:0] flags_wdata
);

  typedef struct packed {
    logic [1:0] ctrl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_s;

  localparam apb_s APB_RST = '{ctrl: `SRFU_CTRL_RST, pready: 1'b0,
                              pslverr: 1'b0, prdata: 32'h0000_0000};

  apb_s q_r;
  apb_s q_nxt;
  logic wr_fire;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // Write lands on the edge where the master sees pready
  assign wr_fire = psel && penable && q_r.pready && pwrite && !q_r.pslverr;
  assign flags_we = wr_fire && hit(paddr, `SRFU_OFF_FLAGS) && pstrb[0];
  assign flags_wdata = pwdata[7:0];

  always_comb begin
    q_nxt = q_r;
    q_nxt.pready = 1'b0;
    q_nxt.pslverr = 1'b0;
    if (psel && penable && !q_r.pready) begin
      q_nxt.pready = 1'b1;
      q_nxt.prdata = 32'h0000_0000;
      if (hit(paddr, `SRFU_OFF_FLAGS)) begin
        q_nxt.prdata = {24'h00_0000, flags};
      end else if (hit(paddr, `SRFU_OFF_RESULT)) begin
        q_nxt.prdata = 32'(result);
      end else if (hit(paddr, `SRFU_OFF_CTRL)) begin
        q_nxt.prdata = {30'h0000_0000, q_r.ctrl};
      end else if (hit(paddr, `SRFU_OFF_STATE)) begin
        q_nxt.prdata = {30'h0000_0000, op_ready, halted};
      end else begin
        q_nxt.pslverr = 1'b1;
      end
    end
    if (wr_fire && hit(paddr, `SRFU_OFF_CTRL) && pstrb[0]) begin
      q_nxt.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= APB_RST;
    end else if (core_ce) begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign exec_en = q_r.ctrl[`SRFU_CTRL_EXEC_EN];
  assign brk_en = q_r.ctrl[`SRFU_CTRL_BRK_EN];

endmodule // srfu_apb_regs

// file: verilog/srfu_top.sv
`timescale 1ns/1ps
`include "srfu_consts.svh"

module srfu_top import srfu_pkg::*; #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire logic op_valid,
  input wire srfu_op_e op_code,
  input wire logic [DATA_W-1:0] op_src,
  input wire logic [$clog2(DATA_W)-1:0] op_bit,
  input wire logic [2:0] op_flag,
  input wire logic dbg_resume,
  output logic op_ready,
  output logic [DATA_W-1:0] res_data,
  output logic res_we,
  output logic [7:0] status_flags_reg,
  output logic sleep_req,
  output logic wdt_restart,
  output logic dbg_halted,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int MSB = DATA_W - 1;
  localparam int HALF = DATA_W / 2;

  if (DATA_W < 2 || (DATA_W % 2) != 0) begin : g_bad_width
    $error("DATA_W must be even and at least 2");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W too small for register map");
  end
  if (`SRFU_OP_CYCLES != 1) begin : g_bad_cycles
    $error("Datapath only serves single-clock operations");
  end
  if (DATA_W > 32) begin : g_bad_read
    $error("Result must fit the 32-bit read path");
  end
  if (ADDR_W > 32) begin : g_bad_paddr
    $error("APB address is at most 32 bits wide");
  end

  typedef struct packed {
    srfu_state_e state;
    logic [7:0] flags;
    logic [DATA_W-1:0] res;
    logic res_we;
    logic sleep;
    logic wdt;
    logic halted;
    logic rdy;
  } core_s;

  localparam core_s CORE_RST = '{state: ST_RUN, flags: `SRFU_FLAGS_RST,
                                res: '0, res_we: 1'b0, sleep: 1'b0,
                                wdt: 1'b0, halted: 1'b0, rdy: 1'b0};

  core_s q_r;
  core_s q_nxt;
  logic exec_en;
  logic brk_en;
  logic sw_flags_we;
  logic [7:0] sw_flags;
  logic accept;
  logic [DATA_W:0] sh;

  // Returns {carry_out, result}; non-shift codes pass through unused
  function automatic logic [DATA_W:0] shift_calc(input srfu_op_e op,
                                                 input logic [MSB:0] v,
                                                 input logic cin);
    case (op)
      OP_SHIFT_LEFT_LOGICAL: shift_calc = {v, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: shift_calc = {v[0], 1'b0, v[MSB:1]};
      OP_ROTATE_LEFT_VIA_CARRY: shift_calc = {v, cin};
      OP_ROTATE_RIGHT_VIA_CARRY: shift_calc = {v[0], cin, v[MSB:1]};
      OP_SHIFT_RIGHT_ARITH: shift_calc = {v[0], v[MSB], v[MSB:1]};
      default: shift_calc = {cin, v};
    endcase
  endfunction

  // Loads Z, C, N and V; S and H are left as they were
  function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                             input logic [DATA_W:0] s);
    logic [7:0] o;
    o = f;
    o[`SRFU_FLAG_Z] = (s[MSB:0] == '0);
    o[`SRFU_FLAG_C] = s[DATA_W];
    o[`SRFU_FLAG_N] = s[MSB];
    o[`SRFU_FLAG_V] = s[MSB] ^ s[DATA_W];
    shift_flags = o;
  endfunction

  // Ops offered while not ready are dropped without a sign
  assign accept = op_valid && q_r.rdy;
  assign sh = shift_calc(op_code, op_src, q_r.flags[`SRFU_FLAG_C]);

  always_comb begin
    q_nxt = q_r;
    q_nxt.res_we = 1'b0;
    q_nxt.sleep = 1'b0;
    q_nxt.wdt = 1'b0;
    // Software write first so a same-cycle operation wins its bits
    if (sw_flags_we) begin
      q_nxt.flags = sw_flags;
    end
    unique case (q_r.state)
      ST_RUN: begin
        if (accept) begin
          unique case (op_code)
            OP_SHIFT_LEFT_LOGICAL: begin
              q_nxt.res = sh[MSB:0];
              q_nxt.res_we = 1'b1;
              q_nxt.flags = shift_flags(q_nxt.flags, sh);
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
              q_nxt.res = sh[MSB:0];
              q_nxt.res_we = 1'b1;
              q_nxt.flags = shift_flags(q_nxt.flags, sh);
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
              q_nxt.res = sh[MSB:0];
              q_nxt.res_we = 1'b1;
              q_nxt.flags = shift_flags(q_nxt.flags, sh);
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
              q_nxt.res = sh[MSB:0];
              q_nxt.res_we = 1'b1;
              q_nxt.flags = shift_flags(q_nxt.flags, sh);
            end
            OP_SHIFT_RIGHT_ARITH: begin
              q_nxt.res = sh[MSB:0];
              q_nxt.res_we = 1'b1;
              q_nxt.flags = shift_flags(q_nxt.flags, sh);
            end
            OP_NIBBLE_EXCHANGE: begin
              q_nxt.res = {op_src[HALF-1:0], op_src[MSB:HALF]};
              q_nxt.res_we = 1'b1;
            end
            OP_FLAG_SET_BY_INDEX: begin
              q_nxt.flags[op_flag] = 1'b1;
            end
            OP_FLAG_CLEAR_BY_INDEX: begin
              q_nxt.flags[op_flag] = 1'b0;
            end
            OP_BIT_TO_TRANSFER_FLAG: begin
              q_nxt.flags[`SRFU_FLAG_T] = op_src[op_bit];
            end
            OP_TRANSFER_FLAG_TO_BIT: begin
              q_nxt.res = op_src;
              q_nxt.res[op_bit] = q_r.flags[`SRFU_FLAG_T];
              q_nxt.res_we = 1'b1;
            end
            OP_CARRY_SET: begin
              q_nxt.flags[`SRFU_FLAG_C] = 1'b1;
            end
            OP_CARRY_CLEAR: begin
              q_nxt.flags[`SRFU_FLAG_C] = 1'b0;
            end
            OP_NEGATIVE_SET: begin
              q_nxt.flags[`SRFU_FLAG_N] = 1'b1;
            end
            OP_NEGATIVE_CLEAR: begin
              q_nxt.flags[`SRFU_FLAG_N] = 1'b0;
            end
            OP_ZERO_SET: begin
              q_nxt.flags[`SRFU_FLAG_Z] = 1'b1;
            end
            OP_ZERO_CLEAR: begin
              q_nxt.flags[`SRFU_FLAG_Z] = 1'b0;
            end
            OP_IRQ_ENABLE: begin
              q_nxt.flags[`SRFU_FLAG_I] = 1'b1;
            end
            OP_IRQ_DISABLE: begin
              q_nxt.flags[`SRFU_FLAG_I] = 1'b0;
            end
            OP_SIGNED_FLAG_SET_OP: begin
              q_nxt.flags[`SRFU_FLAG_S] = 1'b1;
            end
            OP_SIGNED_FLAG_CLEAR_OP: begin
              q_nxt.flags[`SRFU_FLAG_S] = 1'b0;
            end
            OP_OVERFLOW_FLAG_SET_OP: begin
              q_nxt.flags[`SRFU_FLAG_V] = 1'b1;
            end
            OP_OVERFLOW_FLAG_CLEAR_OP: begin
              q_nxt.flags[`SRFU_FLAG_V] = 1'b0;
            end
            OP_TRANSFER_FLAG_SET_OP: begin
              q_nxt.flags[`SRFU_FLAG_T] = 1'b1;
            end
            OP_TRANSFER_FLAG_CLEAR_OP: begin
              q_nxt.flags[`SRFU_FLAG_T] = 1'b0;
            end
            OP_HALF_CARRY_CLEAR_OP: begin
              q_nxt.flags[`SRFU_FLAG_H] = 1'b0;
            end
            OP_SLEEP: begin
              q_nxt.sleep = 1'b1;
            end
            OP_WATCHDOG_RESTART_OP: begin
              q_nxt.wdt = 1'b1;
            end
            OP_DEBUG_BREAK: begin
              // Without debug enabled the break behaves as an idle slot
              if (brk_en) begin
                q_nxt.state = ST_HALT;
              end
            end
            OP_IDLE_INSTRUCTION: begin
              q_nxt.res_we = 1'b0;
            end
            default: begin
              q_nxt.res_we = 1'b0;
            end
          endcase
        end
      end
      // Halted core refuses every op until the debugger lets go
      ST_HALT: begin
        if (dbg_resume) begin
          q_nxt.state = ST_RUN;
        end
      end
    endcase
    q_nxt.halted = (q_nxt.state == ST_HALT);
    // Ready follows the next state, so a break blocks the very next op
    q_nxt.rdy = (q_nxt.state == ST_RUN) && exec_en;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= CORE_RST;
    end else if (core_ce) begin
      q_r <= q_nxt;
    end
  end

  srfu_apb_regs #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .core_ce(core_ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .flags(q_r.flags),
    .result(q_r.res),
    .halted(q_r.halted),
    .op_ready(q_r.rdy),
    .exec_en(exec_en),
    .brk_en(brk_en),
    .flags_we(sw_flags_we),
    .flags_wdata(sw_flags)
  );

  assign op_ready = q_r.rdy;
  assign res_data = q_r.res;
  assign res_we = q_r.res_we;
  assign status_flags_reg = q_r.flags;
  assign sleep_req = q_r.sleep;
  assign wdt_restart = q_r.wdt;
  assign dbg_halted = q_r.halted;

endmodule // srfu_top

// file: test/srfu_regfile_model.sv
`timescale 1ns/1ps
module srfu_regfile_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic res_we,
  input wire logic [7:0] res_data,
  output logic [7:0] reg_q,
  output logic [7:0] wr_cnt
);
  // Write-back target; the count exposes stray writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_q <= 8'h00;
      wr_cnt <= 8'h00;
    end else if (res_we) begin
      reg_q <= res_data;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule // srfu_regfile_model

// file: test/srfu_top_asserts.sv
`timescale 1ns/1ps
module srfu_top_asserts import srfu_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire logic op_valid,
  input wire srfu_op_e op_code,
  input wire logic [DATA_W-1:0] op_src,
  input wire logic [$clog2(DATA_W)-1:0] op_bit,
  input wire logic op_ready,
  input wire logic [DATA_W-1:0] res_data,
  input wire logic res_we,
  input wire logic [7:0] status_flags_reg,
  input wire logic sleep_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic tk;
  assign tk = core_ce && op_valid && op_ready;
  chk_shl_res: assert property (
    tk && op_code == OP_SHIFT_LEFT_LOGICAL |=> res_we &&
    res_data == ($past(op_src) << 1)) else $error("shl bad");
  chk_shr_res: assert property (
    tk && op_code == OP_SHIFT_RIGHT_LOGICAL |=> status_flags_reg[0] ==
    $past(op_src[0]) && res_data == ($past(op_src) >> 1))
    else $error("shr bad");
  chk_rol_res: assert property (
    tk && op_code == OP_ROTATE_LEFT_VIA_CARRY |=> res_data ==
    {$past(op_src[DATA_W-2:0]), $past(status_flags_reg[0])} &&
    status_flags_reg[0] == $past(op_src[DATA_W-1])) else $error("rol bad");
  chk_ror_res: assert property (
    tk && op_code == OP_ROTATE_RIGHT_VIA_CARRY |=> res_data ==
    {$past(status_flags_reg[0]), $past(op_src[DATA_W-1:1])} &&
    status_flags_reg[0] == $past(op_src[0])) else $error("ror bad");
  chk_asr_res: assert property (
    tk && op_code == OP_SHIFT_RIGHT_ARITH |=> res_data ==
    {$past(op_src[DATA_W-1]), $past(op_src[DATA_W-1:1])})
    else $error("asr bad");
  chk_swap_res: assert property (
    tk && op_code == OP_NIBBLE_EXCHANGE |=> $stable(status_flags_reg) &&
    res_data == {$past(op_src[3:0]), $past(op_src[7:4])})
    else $error("swap bad");
  chk_bst_flag: assert property (
    tk && op_code == OP_BIT_TO_TRANSFER_FLAG |=> status_flags_reg[6] ==
    $past(op_src[op_bit]) && $stable(status_flags_reg[5:0]))
    else $error("bit store bad");
  chk_sleep_req: assert property (
    tk && op_code == OP_SLEEP |=> sleep_req && $stable(status_flags_reg))
    else $error("sleep bad");
  chk_sleep_cause: assert property (
    sleep_req |-> $past(tk) && $past(op_code) == OP_SLEEP)
    else $error("stray sleep");
endmodule // srfu_top_asserts

bind srfu_top srfu_top_asserts #(.DATA_W(DATA_W)) srfu_top_asserts_i (
  .core_clk(core_clk), .resetn(resetn), .core_ce(core_ce),
  .op_valid(op_valid), .op_code(op_code), .op_src(op_src),
  .op_bit(op_bit), .op_ready(op_ready), .res_data(res_data),
  .res_we(res_we), .status_flags_reg(status_flags_reg),
  .sleep_req(sleep_req));

// file: test/tb_srfu_top.sv
`timescale 1ns/1ps
module tb_srfu_top import srfu_pkg::*;;
  logic core_clk, resetn, core_ce, op_valid, dbg_resume, err;
  srfu_op_e op_code;
  logic [7:0] op_src, res_data, status_flags_reg, reg_q, wr_cnt, paddr;
  logic [2:0] op_bit, op_flag;
  logic op_ready, res_we, sleep_req, wdt_restart, dbg_halted;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  srfu_top srfu_top_i (.core_clk(core_clk), .resetn(resetn),
    .core_ce(core_ce), .op_valid(op_valid), .op_code(op_code),
    .op_src(op_src), .op_bit(op_bit), .op_flag(op_flag),
    .dbg_resume(dbg_resume), .op_ready(op_ready), .res_data(res_data),
    .res_we(res_we), .status_flags_reg(status_flags_reg),
    .sleep_req(sleep_req), .wdt_restart(wdt_restart),
    .dbg_halted(dbg_halted), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  srfu_regfile_model srfu_regfile_model_i (.core_clk(core_clk),
    .resetn(resetn), .res_we(res_we), .res_data(res_data),
    .reg_q(reg_q), .wr_cnt(wr_cnt));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Returns 1 ns after the taking edge, once the results have landed
  task automatic op(srfu_op_e c, logic [7:0] s, logic [2:0] b);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_src <= s;
    op_bit <= b;
    op_flag <= b;
    do @(posedge core_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic t_shift();
    logic [7:0] vals [4] = '{8'h81, 8'h00, 8'h40, 8'hFE};
    logic [7:0] v, r;
    logic c, co;
    for (int i = 0; i < 40; i++) begin
      v = vals[(i / 2) % 4];
      c = i[0];
      case (i / 8)
        0: {co, r} = {v, 1'b0};
        1: {r, co} = {1'b0, v};
        2: {co, r} = {v, c};
        3: {r, co} = {c, v};
        default: {r, co} = {v[7], v};
      endcase
      apb(1'b1, 8'h00, {24'h0, 7'h38, c});
      op(srfu_op_e'(i / 8 + 1), v, 3'd0);
      chk("shift res", {res_we, res_data}, {1'b1, r});
      chk("shift flags", status_flags_reg,
        {4'h7, r[7] ^ co, r[7], r == 8'h00, co});
    end
    $display("shift test done");
  endtask

  task automatic t_swap();
    apb(1'b1, 8'h00, 32'h000000A5);
    op(OP_NIBBLE_EXCHANGE, 8'h3C, 3'd0);
    chk("swap", {res_data, status_flags_reg}, 16'hC3A5);
    @(posedge core_clk);
    #1;
    chk("regfile", reg_q, 8'hC3);
    $display("swap test done");
  endtask

  task automatic t_bit();
    logic [7:0] m;
    apb(1'b1, 8'h00, 32'h000000BF);
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      op(OP_BIT_TO_TRANSFER_FLAG, m, 3'(b));
      chk("bit store", status_flags_reg, 8'hFF);
      op(OP_TRANSFER_FLAG_TO_BIT, 8'h00, 3'(b));
      chk("bit load", {res_data, status_flags_reg}, {m, 8'hFF});
      op(OP_BIT_TO_TRANSFER_FLAG, ~m, 3'(b));
      chk("bit store", status_flags_reg, 8'hBF);
      op(OP_TRANSFER_FLAG_TO_BIT, 8'hFF, 3'(b));
      chk("bit load", {res_data, status_flags_reg}, {~m, 8'hBF});
    end
    $display("bit test done");
  endtask

  task automatic t_flag();
    int bp [7] = '{0, 2, 1, 7, 4, 3, 6};
    logic [7:0] e;
    e = 8'h3C;
    apb(1'b1, 8'h00, {24'h0, e});
    // Codes come in set/clear pairs, then the half-carry clear
    for (int j = 0; j < 15; j++) begin
      if (j < 14) e[bp[j / 2]] = ~j[0];
      else e[5] = 1'b0;
      op(srfu_op_e'(j + 11), 8'h00, 3'd0);
      chk("flag op", status_flags_reg, e);
    end
    for (int i = 0; i < 16; i++) begin
      e[i / 2] = ~i[0];
      op(i[0] ? OP_FLAG_CLEAR_BY_INDEX : OP_FLAG_SET_BY_INDEX, 8'h00,
        3'(i / 2));
      chk("flag index", status_flags_reg, e);
    end
    $display("flag test done");
  endtask

  task automatic t_ctl();
    logic [7:0] n;
    apb(1'b1, 8'h00, 32'h00000096);
    n = wr_cnt;
    op(OP_IDLE_INSTRUCTION, 8'h55, 3'd0);
    chk("idle", {res_we, status_flags_reg}, 9'h096);
    op(OP_SLEEP, 8'h55, 3'd0);
    chk("sleep", {sleep_req, status_flags_reg}, 9'h196);
    op(OP_WATCHDOG_RESTART_OP, 8'h55, 3'd0);
    chk("wdt", {sleep_req, wdt_restart, status_flags_reg}, 10'h196);
    @(posedge core_clk);
    #1;
    chk("wdt pulse", wdt_restart, 1'b0);
    chk("no write", wr_cnt, n);
    op(OP_DEBUG_BREAK, 8'h55, 3'd0);
    chk("break", {dbg_halted, status_flags_reg}, 9'h196);
    @(posedge core_clk);
    #1;
    chk("halt ready", op_ready, 1'b0);
    @(posedge core_clk);
    dbg_resume <= 1'b1;
    @(posedge core_clk);
    dbg_resume <= 1'b0;
    #1;
    chk("resume", {dbg_halted, op_ready}, 2'b01);
    $display("control test done");
  endtask

  task automatic t_cfg();
    logic [7:0] n;
    op(OP_NIBBLE_EXCHANGE, 8'h12, 3'd0);
    apb(1'b0, 8'h04, 32'h0);
    chk("result read", rd, 32'h21);
    apb(1'b0, 8'h0C, 32'h0);
    chk("state read", rd, 32'h2);
    pstrb <= 4'h0;
    apb(1'b1, 8'h00, 32'hFF);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk("strobe off", rd, 32'h96);
    apb(1'b1, 8'h08, 32'h1);
    op(OP_DEBUG_BREAK, 8'h00, 3'd0);
    chk("break off", {dbg_halted, op_ready}, 2'b01);
    apb(1'b1, 8'h08, 32'h0);
    n = wr_cnt;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= OP_SHIFT_LEFT_LOGICAL;
    op_src <= 8'h01;
    repeat (3) @(posedge core_clk);
    #1;
    chk("exec off", {op_ready, wr_cnt}, {1'b0, n});
    apb(1'b1, 8'h08, 32'h3);
    @(posedge core_clk);
    core_ce <= 1'b0;
    repeat (3) @(posedge core_clk);
    op_valid <= 1'b0;
    core_ce <= 1'b1;
    #1;
    chk("frozen", {op_ready, res_we, res_data, wr_cnt}, {2'b10, 8'h21, n});
    $display("config test done");
  endtask

  initial begin
    resetn = 1'b0;
    core_ce = 1'b1;
    op_valid = 1'b0;
    op_code = OP_IDLE_INSTRUCTION;
    op_src = 8'h00;
    op_bit = 3'd0;
    op_flag = 3'd0;
    dbg_resume = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk("flags reset", status_flags_reg, 8'h00);
    apb(1'b0, 8'h08, 32'h0);
    chk("ctrl reset", rd, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", err, 1'b1);
    t_shift();
    t_swap();
    t_bit();
    t_flag();
    t_ctl();
    t_cfg();
    end_sim();
  end
endmodule // tb_srfu_top
